// ---- gain_mute_ctrl.sv ----
// Four-channel post-conversion gain, mute, summing and calibration control
//
// Contract
// - Four independent gain codes; code zero gives +60 dB
// - Each code step lowers gain by 0.375 dB
// - Code A0 passes samples at unity gain
// - Code FE deepest attenuation; code FF mutes channel
// - Gain registers reset to A0, software read/write
// - Bits 7:6 select four, two or one channel
// - Master mute bit 4 silences every channel
`timescale 1ns/1ps
`include "gain_mute_regs.svh"

module gain_mute_ctrl #(
   parameter int SAMPLE_W = 24
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic smp_valid_in,
   input wire logic signed [SAMPLE_W-1:0] ch1_smp_in,
   input wire logic signed [SAMPLE_W-1:0] ch2_smp_in,
   input wire logic signed [SAMPLE_W-1:0] ch3_smp_in,
   input wire logic signed [SAMPLE_W-1:0] ch4_smp_in,
   output logic smp_valid_out,
   output logic signed [SAMPLE_W-1:0] ch1_smp_out,
   output logic signed [SAMPLE_W-1:0] ch2_smp_out,
   output logic signed [SAMPLE_W-1:0] ch3_smp_out,
   output logic signed [SAMPLE_W-1:0] ch4_smp_out,
   output logic offset_calibration_trigger,
   output logic global_silence
);
   localparam int P1_W = SAMPLE_W + 25 - `GC_COARSE_SHIFT;
   localparam int P2_W = P1_W + 17 - `GC_FINE_SHIFT;
   localparam logic signed [SAMPLE_W-1:0] SMP_MAX = {1'b0, {(SAMPLE_W-1){1'b1}}};
   localparam logic signed [SAMPLE_W-1:0] SMP_MIN = {1'b1, {(SAMPLE_W-1){1'b0}}};

   logic [7:0] gain_reg [4];
   logic [7:0] misc_reg;
   logic signed [SAMPLE_W-1:0] smp_in [4];
   logic signed [SAMPLE_W-1:0] comb_smp [4];
   logic signed [P1_W-1:0] stage1_reg [4];
   logic mute1_reg [4];
   logic [3:0] fine_idx_reg [4];
   logic signed [SAMPLE_W-1:0] out_reg [4];
   logic valid1_reg;
   logic valid2_reg;
   logic signed [SAMPLE_W+1:0] sum_ab;
   logic signed [SAMPLE_W+1:0] sum_cd;
   logic signed [SAMPLE_W+1:0] sum_all;
   gain_mute_pkg::combine_mode_t combine_sel;

   assign smp_in[0] = ch1_smp_in;
   assign smp_in[1] = ch2_smp_in;
   assign smp_in[2] = ch3_smp_in;
   assign smp_in[3] = ch4_smp_in;
   assign combine_sel = gain_mute_pkg::combine_mode_t'(misc_reg[`GC_COMBINE_HI:`GC_COMBINE_LO]);
   assign global_silence = misc_reg[`GC_SILENCE_BIT];
   assign offset_calibration_trigger = misc_reg[`GC_CAL_BIT];

   // Per-channel gain code registers
   generate
      for (genvar i = 0; i < 4; i++)
      begin : g_gain
         always_ff @(posedge clk_sys or negedge rst_b)
         begin
            if (!rst_b)
               gain_reg[i] <= `GC_GAIN_RST;
            else if (reg_wr && reg_addr == 8'(`GC_ADDR_CH1 + i))
               gain_reg[i] <= reg_wdata;
         end
      end
   endgenerate

   // Summing, mute and calibration control register
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         misc_reg <= `GC_MISC_RST;
      else if (reg_wr && reg_addr == `GC_ADDR_MISC)
         misc_reg <= reg_wdata;
   end

   // Registered readback; unmapped offsets read zero
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         reg_rdata <= `GC_READ_ZERO;
      else if (reg_rd)
      begin
         unique case (reg_addr)
            `GC_ADDR_CH1: reg_rdata <= gain_reg[0];
            `GC_ADDR_CH2: reg_rdata <= gain_reg[1];
            `GC_ADDR_CH3: reg_rdata <= gain_reg[2];
            `GC_ADDR_CH4: reg_rdata <= gain_reg[3];
            `GC_ADDR_MISC: reg_rdata <= misc_reg;
            default: reg_rdata <= `GC_READ_ZERO;
         endcase
      end
   end

   // Channel combining ahead of the gain stage
   always_comb
   begin
      sum_ab = (SAMPLE_W+2)'(smp_in[0]) + (SAMPLE_W+2)'(smp_in[1]);
      sum_cd = (SAMPLE_W+2)'(smp_in[2]) + (SAMPLE_W+2)'(smp_in[3]);
      sum_all = sum_ab + sum_cd;
      comb_smp = smp_in;
      unique case (combine_sel)
         gain_mute_pkg::COMBINE_TWO:
         begin
            comb_smp[0] = SAMPLE_W'(sum_ab >>> 1);
            comb_smp[1] = SAMPLE_W'(sum_cd >>> 1);
            comb_smp[2] = '0;
            comb_smp[3] = '0;
         end
         gain_mute_pkg::COMBINE_ONE:
         begin
            comb_smp[0] = SAMPLE_W'(sum_all >>> 2);
            comb_smp[1] = '0;
            comb_smp[2] = '0;
            comb_smp[3] = '0;
         end
         gain_mute_pkg::COMBINE_FOUR, gain_mute_pkg::COMBINE_RSVD:
            comb_smp = smp_in; // Reserved code runs as four channels
      endcase
   end

   // Two-stage gain multiply per channel: coarse 6 dB, then fine 0.375 dB
   generate
      for (genvar i = 0; i < 4; i++)
      begin : g_chan
         logic signed [SAMPLE_W+24:0] prod1;
         logic signed [P1_W+16:0] prod2;
         logic signed [P2_W-1:0] scaled;
         assign prod1 = comb_smp[i]
            * $signed({1'b0, gain_mute_pkg::coarse_gain(gain_reg[i][7:4])});
         assign prod2 = stage1_reg[i] * $signed({1'b0, gain_mute_pkg::fine_gain(fine_idx_reg[i])});
         assign scaled = P2_W'(prod2 >>> `GC_FINE_SHIFT);

         always_ff @(posedge clk_sys or negedge rst_b)
         begin
            if (!rst_b)
            begin
               stage1_reg[i] <= '0;
               mute1_reg[i] <= 1'b0;
               fine_idx_reg[i] <= '0;
            end
            else if (smp_valid_in)
            begin
               stage1_reg[i] <= P1_W'(prod1 >>> `GC_COARSE_SHIFT);
               mute1_reg[i] <= (gain_reg[i] == `GC_MUTE_CODE) || global_silence;
               fine_idx_reg[i] <= gain_reg[i][3:0];
            end
         end

         always_ff @(posedge clk_sys or negedge rst_b)
         begin
            if (!rst_b)
               out_reg[i] <= '0;
            else if (valid1_reg)
            begin
               if (mute1_reg[i])
                  out_reg[i] <= '0;
               else if (scaled > P2_W'(SMP_MAX))
                  out_reg[i] <= SMP_MAX;
               else if (scaled < P2_W'(SMP_MIN))
                  out_reg[i] <= SMP_MIN;
               else
                  out_reg[i] <= SAMPLE_W'(scaled);
            end
         end
      end
   endgenerate

   // Sample strobe pipeline
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         valid1_reg <= 1'b0;
         valid2_reg <= 1'b0;
      end
      else
      begin
         valid1_reg <= smp_valid_in;
         valid2_reg <= valid1_reg;
      end
   end

   assign smp_valid_out = valid2_reg;
   assign ch1_smp_out = out_reg[0];
   assign ch2_smp_out = out_reg[1];
   assign ch3_smp_out = out_reg[2];
   assign ch4_smp_out = out_reg[3];

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence ch1_take(logic [7:0] code, logic signed [SAMPLE_W-1:0] smp);
      smp_valid_in && !global_silence && combine_sel == gain_mute_pkg::COMBINE_FOUR
         && gain_reg[0] == code && ch1_smp_in == smp;
   endsequence

   max_gain_out_a: assert property (ch1_take(`GC_MAX_GAIN_CODE, 24'sh000001)
      |-> ##2 smp_valid_out && ch1_smp_out == 24'sh0003E8)
      else $error("code zero not +60 dB");
   step_gain_out_a: assert property (smp_valid_in && !global_silence
      && combine_sel == gain_mute_pkg::COMBINE_FOUR && gain_reg[1] == 8'h01
      && ch2_smp_in == 24'sh000001 |-> ##2 ch2_smp_out == 24'sh0003BD)
      else $error("first step not 0.375 dB down");
   unity_pass_a: assert property (ch1_take(`GC_GAIN_RST, ch1_smp_in)
      |-> ##2 ch1_smp_out == $past(ch1_smp_in, 2))
      else $error("unity code alters sample");
   mute_code_a: assert property (smp_valid_in && gain_reg[2] == `GC_MUTE_CODE
      |-> ##2 smp_valid_out && ch3_smp_out == '0)
      else $error("mute code passes signal");
   reset_gain_a: assert property ($rose(rst_b)
      |-> gain_reg[0] == `GC_GAIN_RST && gain_reg[3] == `GC_GAIN_RST)
      else $error("gain reset not A0");
   gain_readback_a: assert property (reg_wr && reg_addr == `GC_ADDR_CH2
      ##1 !reg_wr ##1 reg_rd && !reg_wr && reg_addr == `GC_ADDR_CH2
      |=> reg_rdata == $past(reg_wdata, 3))
      else $error("gain readback wrong");
   combine_one_a: assert property (smp_valid_in
      && combine_sel == gain_mute_pkg::COMBINE_ONE
      |-> ##2 ch2_smp_out == '0 && ch3_smp_out == '0)
      else $error("one-channel mode leaks");
   master_mute_a: assert property (smp_valid_in && global_silence
      |-> ##2 smp_valid_out && ch1_smp_out == '0 && ch2_smp_out == '0)
      else $error("master mute ignored");
   cal_enable_a: assert property (reg_wr && reg_addr == `GC_ADDR_MISC
      |=> offset_calibration_trigger == $past(reg_wdata[`GC_CAL_BIT]))
      else $error("calibration enable not taken");
endmodule // gain_mute_ctrl

// ---- gain_mute_pkg.sv ----
// Types and gain lookup tables for the post-conversion gain stage
package gain_mute_pkg;
   typedef enum logic [1:0] {COMBINE_FOUR, COMBINE_TWO, COMBINE_ONE, COMBINE_RSVD} combine_mode_t;

   // Coarse 6 dB steps, 14 fractional bits; index = code[7:4]
   function automatic logic [23:0] coarse_gain(input logic [3:0] k);
      unique case (k)
         4'h0: coarse_gain = 24'hFA0000;
         4'h1: coarse_gain = 24'h7D4BFA;
         4'h2: coarse_gain = 24'h3ECC0A;
         4'h3: coarse_gain = 24'h1F7926;
         4'h4: coarse_gain = 24'h0FC620;
         4'h5: coarse_gain = 24'h07E7DB;
         4'h6: coarse_gain = 24'h03F655;
         4'h7: coarse_gain = 24'h01FC5F;
         4'h8: coarse_gain = 24'h00FECA;
         4'h9: coarse_gain = 24'h007FB2;
         4'hA: coarse_gain = 24'h004000;
         4'hB: coarse_gain = 24'h002013;
         4'hC: coarse_gain = 24'h001013;
         4'hD: coarse_gain = 24'h00080F;
         4'hE: coarse_gain = 24'h00040A;
         4'hF: coarse_gain = 24'h000206;
      endcase
   endfunction

   // Fine 0.375 dB steps, 15 fractional bits; index = code[3:0]
   function automatic logic [15:0] fine_gain(input logic [3:0] j);
      unique case (j)
         4'h0: fine_gain = 16'h8000;
         4'h1: fine_gain = 16'h7A98;
         4'h2: fine_gain = 16'h7569;
         4'h3: fine_gain = 16'h7074;
         4'h4: fine_gain = 16'h6BB3;
         4'h5: fine_gain = 16'h6726;
         4'h6: fine_gain = 16'h62CA;
         4'h7: fine_gain = 16'h5E9E;
         4'h8: fine_gain = 16'h5A9E;
         4'h9: fine_gain = 16'h56CA;
         4'hA: fine_gain = 16'h531F;
         4'hB: fine_gain = 16'h4F9C;
         4'hC: fine_gain = 16'h4C3F;
         4'hD: fine_gain = 16'h4906;
         4'hE: fine_gain = 16'h45F0;
         4'hF: fine_gain = 16'h42FC;
      endcase
   endfunction
endpackage

// ---- gain_mute_regs.svh ----
// Register offsets, reset values, field positions and datapath constants
`ifndef GAIN_MUTE_REGS_SVH
`define GAIN_MUTE_REGS_SVH
`define GC_ADDR_CH1 8'h0A
`define GC_ADDR_CH2 8'h0B
`define GC_ADDR_CH3 8'h0C
`define GC_ADDR_CH4 8'h0D
`define GC_ADDR_MISC 8'h0E
`define GC_GAIN_RST 8'hA0
`define GC_MISC_RST 8'h02
`define GC_MUTE_CODE 8'hFF
`define GC_MAX_GAIN_CODE 8'h00
`define GC_COMBINE_HI 7
`define GC_COMBINE_LO 6
`define GC_SILENCE_BIT 4
`define GC_CAL_BIT 0
`define GC_COARSE_SHIFT 14
`define GC_FINE_SHIFT 15
`define GC_READ_ZERO 8'h00
`endif

// ---- post_adc_gain_mute_control_tb_top.sv ----
// Self-checking testbench for the four-channel gain, mute and summing block
`timescale 1ns/1ps
`include "gain_mute_regs.svh"

module post_adc_gain_mute_control_tb_top;
   logic clk_sys;
   logic rst_b;
   logic reg_wr;
   logic reg_rd;
   logic smp_valid_in;
   logic smp_valid_out;
   logic cal;
   logic sil;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic signed [23:0] si [4];
   logic signed [23:0] so [4];
   int err_count;
   int checked;
   int cyc;

   gain_mute_ctrl DUT (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .smp_valid_in(smp_valid_in), .ch1_smp_in(si[0]), .ch2_smp_in(si[1]),
      .ch3_smp_in(si[2]), .ch4_smp_in(si[3]), .smp_valid_out(smp_valid_out),
      .ch1_smp_out(so[0]), .ch2_smp_out(so[1]), .ch3_smp_out(so[2]),
      .ch4_smp_out(so[3]), .offset_calibration_trigger(cal), .global_silence(sil));

   // Verdict and end of run
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("FAIL at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One-cycle write strobe, driven on the falling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask

   // Read data is settled one edge after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_sys);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      chk({16'h0000, reg_rdata}, {16'h0000, exp}, "register read");
   endtask

   // One sample frame; results expected exactly two edges later
   task automatic run(input int a, b, c, d, e0, e1, e2, e3);
      @(negedge clk_sys);
      smp_valid_in = 1'b1;
      si = '{24'(a), 24'(b), 24'(c), 24'(d)};
      @(negedge clk_sys);
      smp_valid_in = 1'b0;
      @(negedge clk_sys);
      chk({23'h000000, smp_valid_out}, 24'h000001, "output strobe");
      chk(so[0], 24'(e0), "channel 1");
      chk(so[1], 24'(e1), "channel 2");
      chk(so[2], 24'(e2), "channel 3");
      chk(so[3], 24'(e3), "channel 4");
   endtask

   // Clock and hang guard
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_count++;
         $display("FAIL at %0t: run did not finish", $time);
         report_and_stop();
      end
   end

   initial
   begin
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      smp_valid_in = 1'b0;
      si = '{24'sh0, 24'sh0, 24'sh0, 24'sh0};
      repeat (6) @(negedge clk_sys);
      rst_b = 1'b1;
      // Reset values, read/write, unmapped place
      for (int k = 0; k < 4; k++) rd(`GC_ADDR_CH1 + 8'(k), 8'hA0);
      rd(`GC_ADDR_MISC, 8'h02);
      chk({22'h0, sil, cal}, 24'h000000, "control outputs after reset");
      // Write then read each gain register with one idle cycle between
      for (int k = 0; k < 4; k++)
      begin
         wr(`GC_ADDR_CH1 + 8'(k), 8'h5A + 8'(k));
         rd(`GC_ADDR_CH1 + 8'(k), 8'h5A + 8'(k));
      end
      wr(8'h0F, 8'h55);
      rd(8'h0F, 8'h00);
      for (int k = 0; k < 4; k++) wr(`GC_ADDR_CH1 + 8'(k), 8'hA0);
      $display("test registers done");
      // Unity gain including full-scale values
      run(1000, -2000, 8388607, -8388608, 1000, -2000, 8388607, -8388608);
      // Independent codes: +60 dB, one step, mute, one step below unity
      wr(`GC_ADDR_CH1, 8'h00);
      wr(`GC_ADDR_CH2, 8'h01);
      wr(`GC_ADDR_CH3, 8'hFF);
      wr(`GC_ADDR_CH4, 8'hA1);
      run(1, 1, 5000, 10000, 1000, 957, 0, 9577);
      wr(`GC_ADDR_CH1, 8'h9F);
      wr(`GC_ADDR_CH2, 8'hFE);
      // Code FE sits 94 fine steps below unity
      run(10000, 100000, 5000, 0, 10441, 1727, 0, 0);
      chk({23'h0, (so[1] >= 1654 && so[1] <= 1727)}, 24'h000001, "deepest step");
      for (int k = 0; k < 4; k++) wr(`GC_ADDR_CH1 + 8'(k), 8'hA0);
      $display("test gain codes done");
      // Master mute over unity gains, then release
      wr(`GC_ADDR_MISC, 8'h12);
      chk({23'h0, sil}, 24'h000001, "silence level");
      run(100, -100, 7, 9, 0, 0, 0, 0);
      wr(`GC_ADDR_MISC, 8'h02);
      run(100, -100, 7, 9, 100, -100, 7, 9);
      $display("test master mute done");
      // Summing modes two, one and reserved
      wr(`GC_ADDR_MISC, 8'h42);
      run(100, 300, -50, -150, 200, -100, 0, 0);
      wr(`GC_ADDR_MISC, 8'h82);
      run(100, 300, -50, -150, 50, 0, 0, 0);
      wr(`GC_ADDR_MISC, 8'hC2);
      run(100, 300, -50, -150, 100, 300, -50, -150);
      rd(`GC_ADDR_MISC, 8'hC2);
      $display("test summing done");
      // Calibration enable level
      wr(`GC_ADDR_MISC, 8'h03);
      chk({23'h0, cal}, 24'h000001, "calibration on");
      wr(`GC_ADDR_MISC, 8'h02);
      chk({23'h0, cal}, 24'h000000, "calibration off");
      $display("test calibration done");
      report_and_stop();
   end
endmodule // post_adc_gain_mute_control_tb_top
